/* File: bench/adc_trigger_clock_control_tb_top.sv */
// Purpose: register level tests of the trigger and time control
// Assumes: 50 MHz clock, reset held five cycles
// Notes:   conversion length checked to the exact cycle count
`timescale 1ns/10ps
module adc_trigger_clock_control_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    atc_pkg::atc_bus_t bus = '0;
    logic tmr = 1'b0;
    logic pin_n = 1'b1;
    logic [7:0] rdata;
    logic irq;
    logic converting;
    logic [3:0] channel;
    int failures = 0;
    int total_checks = 0;
    int n;
    logic [9:0] t_tab [4] = '{atc_pkg::CONV_T0, atc_pkg::CONV_T1, atc_pkg::CONV_T2,
                              atc_pkg::CONV_T3};
    atc_ctrl DUT (.clk(clk), .reset(reset), .addr(bus.addr), .wdata(bus.wdata),
        .wr(bus.wr), .rd(bus.rd), .timer_trigger(tmr), .external_trigger_pin_n(pin_n),
        .rdata(rdata), .irq(irq), .converting(converting), .channel(channel));
    always #10 clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one-cycle strobes, released at the edge that takes them
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : put
    task automatic get(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check("read data", 16'(rdata & m), 16'(exp));
    endtask : get
    task automatic wait_idle();
        n = 0;
        while (converting === 1'b1 && n < 800) begin
            @(posedge clk);
            #1 n++;
        end
        // a conversion that never ends is a fault, not something to wait out
        check("conversion end", 16'(converting), 16'h0000);
    endtask : wait_idle
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // watchdog, far beyond the roughly 1400 cycles the tests need
    initial begin
        #200000;
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        get(atc_pkg::OFS_TRIG_CLK, 8'h33, 8'hFF);
        put(atc_pkg::OFS_TRIG_CLK, 8'h0F);
        get(atc_pkg::OFS_TRIG_CLK, 8'h3F, 8'hFF);
        get(4'h9, 8'h00, 8'hFF);
        $display("test registers done");
        // every trigger code against both hardware sources
        for (int t = 0; t < 4; t++) begin
            put(atc_pkg::OFS_TRIG_CLK, {t[1:0], 6'h3F});
            @(posedge clk) tmr <= 1'b1;
            @(posedge clk) tmr <= 1'b0;
            repeat (3) @(posedge clk);
            #1 check("timer start", converting, t == 1);
            wait_idle();
            @(posedge clk) pin_n <= 1'b0;
            repeat (6) @(posedge clk);
            #1 check("pin start", converting, t == 3);
            @(posedge clk) pin_n <= 1'b1;
            wait_idle();
        end
        get(atc_pkg::OFS_IRQ_STATUS, 8'h03, 8'hFF);
        $display("test triggers done");
        put(atc_pkg::OFS_IRQ_MASK, 8'h01);
        for (int c = 0; c < 4; c++) begin
            put(atc_pkg::OFS_TRIG_CLK, {4'h3, c[1:0], 2'h3});
            put(atc_pkg::OFS_STATUS_CTRL, 8'h20);
            #1 wait_idle();
            check("conversion time", 16'(n), {6'h00, t_tab[c]});
        end
        $display("test times done");
        check("irq", irq, 1'b1);
        get(atc_pkg::OFS_IRQ_STATUS, 8'h01, 8'h05);
        repeat (2) @(posedge clk);
        #1 check("irq", irq, 1'b0);
        get(atc_pkg::OFS_STATUS_CTRL, 8'h80, 8'hFF);
        put(atc_pkg::OFS_STATUS_CTRL, 8'h80);
        get(atc_pkg::OFS_STATUS_CTRL, 8'h80, 8'hFF);
        put(atc_pkg::OFS_STATUS_CTRL, 8'h00);
        get(atc_pkg::OFS_STATUS_CTRL, 8'h00, 8'hFF);
        $display("test end flag done");
        put(atc_pkg::OFS_STATUS_CTRL, 8'h24);
        #1 check("bad channel", converting, 1'b0);
        get(atc_pkg::OFS_IRQ_STATUS, 8'h04, 8'h05);
        $display("test channel done");
        // scan over channels 0..1 at 68 states each, then stop by software
        put(atc_pkg::OFS_STATUS_CTRL, 8'h31);
        repeat (100) @(posedge clk);
        #1 check("scan channel", 16'(channel), 16'h0001);
        repeat (50) @(posedge clk);
        #1 check("scan running", 16'(converting), 16'h0001);
        get(atc_pkg::OFS_STATUS_CTRL, 8'hB1, 8'hFF);
        get(atc_pkg::OFS_RESULT, 8'h01, 8'hFF);
        check("irq", 16'(irq), 16'h0001);
        put(atc_pkg::OFS_STATUS_CTRL, 8'h11);
        #1 check("scan stopped", 16'(converting), 16'h0000);
        $display("test scan done");
        test_done();
    end
endmodule : adc_trigger_clock_control_tb_top

/* File: bench/atc_ctrl_monitor.sv */
// Purpose: port checks of the converter trigger and time control
// Assumes: one clock, async active-high reset
// Notes:   bound into every atc_ctrl instance
`timescale 1ns/10ps
module atc_ctrl_monitor (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       timer_trigger,
    input wire logic       external_trigger_pin_n,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    input wire logic       converting,
    input wire logic [3:0] channel
);
    logic [9:0] run_q;
    logic [9:0] run_d;
    // cycles spent converting, saturating so scan mode cannot wrap it
    always_comb begin
        run_d = converting ? run_q + {9'h0, run_q != 10'h3FF} : 10'h0;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 10'h0;
        end else begin
            run_q <= run_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence start_wr;
        wr && addr == atc_pkg::OFS_STATUS_CTRL && wdata[5] && !wdata[4];
    endsequence
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd && addr > atc_pkg::OFS_RESULT |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_fixed_ones: assert property (rd && addr == atc_pkg::OFS_TRIG_CLK |=>
        (rdata & atc_pkg::TC_FIXED_ONES) == atc_pkg::TC_FIXED_ONES)
        else $error("fixed bits not one");
    a_soft_start: assert property (start_wr ##0 (wdata[3:2] == 2'b00 && !converting)
        |=> converting) else $error("software start ignored");
    a_bad_channel: assert property (start_wr ##0 (wdata[3:2] == 2'b01 && !converting)
        |=> !converting) else $error("prohibited channel started");
    a_conv_min: assert property ($fell(converting) &&
        !($past(wr) && $past(addr) == atc_pkg::OFS_STATUS_CTRL) |-> run_q >= 10'd66)
        else $error("conversion ended too early");
    a_irq_cleared: assert property (rd && addr == atc_pkg::OFS_IRQ_STATUS && !converting
        && !timer_trigger && $past(external_trigger_pin_n, 2) |=> !irq)
        else $error("interrupt stays after status read");
    a_idle_stays: assert property ((external_trigger_pin_n [*4]) ##0 (!converting && !wr
        && !timer_trigger && !$past(timer_trigger)) |=> !converting)
        else $error("conversion began without a source");
endmodule : atc_ctrl_monitor
bind atc_ctrl atc_ctrl_monitor u_mon (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .timer_trigger(timer_trigger),
    .external_trigger_pin_n(external_trigger_pin_n), .rdata(rdata), .irq(irq),
    .converting(converting), .channel(channel));

/* File: rtl/atc_ctrl.sv */
// Purpose: trigger source and conversion time control of the converter
// Assumes: plain register port; trigger pin asynchronous, timer trigger synchronous
// Notes:   the analog core is modelled only by its conversion time
//          scan mode reuses the single-mode maximum for every channel, so a scan
//          group takes slightly longer than a fixed scan figure would suggest
//          channel and mode changes during a conversion are not checked here;
//          software must stop the converter first, as for the trigger and time fields
//
// Operation
// - trigger field adds timer or external pin start to software start; code 10 adds nothing
// - bits 5 and 4 read as one; writes ignored
// - time select gives 530, 266, 134 or 68 states per conversion
// - bits 1 and 0 read as one; software writes only ones
// - end flag clears only when software writes zero to it
// - after reset trigger and time fields are zero
// - start bit set by any source; single mode self-clears, scan holds
// - mode bit zero converts once, one repeats a channel group
`timescale 1ns/10ps
module atc_ctrl (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [3:0]        addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    input  wire logic              timer_trigger,
    input  wire logic              external_trigger_pin_n,
    output logic      [7:0]        rdata,
    output logic                   irq,
    output logic                   converting,
    output logic      [3:0]        channel
);
    atc_pkg::atc_bus_t  bus;
    atc_pkg::atc_state_t st_q, st_d;

    logic [7:0] sc_q, sc_d;             // end flag, irq en, start, scan, channel
    logic [3:0] tc_q, tc_d;             // trigger [3:2], time select [1:0]
    logic [atc_pkg::EV_W-1:0] ev_q, ev_d;
    logic [atc_pkg::EV_W-1:0] mask_q, mask_d;
    logic [3:0] chan_q, chan_d;
    logic [3:0] last_q, last_d;
    logic [7:0] rdata_q, rdata_d;
    logic       irq_q, irq_d;
    logic       pin_s1_q, pin_s2_q, pin_s3_q;
    logic       conv_load;
    logic       conv_done;
    logic [9:0] span;
    logic       trig_fire;
    logic       code_ok;
    logic [7:0] sc_w;                   // status/control after writes and triggers
    logic       end_set;
    logic       bad_set;
    logic       group_end;
    logic       sc_hit, tc_hit, ev_hit, mask_hit;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign sc_hit   = bus.addr == atc_pkg::OFS_STATUS_CTRL;
    assign tc_hit   = bus.addr == atc_pkg::OFS_TRIG_CLK;
    assign ev_hit   = bus.addr == atc_pkg::OFS_IRQ_STATUS;
    assign mask_hit = bus.addr == atc_pkg::OFS_IRQ_MASK;

    // two-stage synchroniser for the pin, then a third stage for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= external_trigger_pin_n;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // hardware trigger qualified by the selected source; code 10 fires nothing
    always_comb begin
        unique case (tc_q[3:2])
            atc_pkg::TRG_TMR: trig_fire = timer_trigger;
            atc_pkg::TRG_EXT: trig_fire = pin_s3_q & ~pin_s2_q;
            default:          trig_fire = 1'b0;
        endcase
    end

    // conversion time per clock select code
    always_comb begin
        unique case (tc_q[1:0])
            2'h0:    span = atc_pkg::CONV_T0;
            2'h1:    span = atc_pkg::CONV_T1;
            2'h2:    span = atc_pkg::CONV_T2;
            default: span = atc_pkg::CONV_T3;
        endcase
    end

    // software view of status/control before the sequencer acts on it
    always_comb begin
        sc_w = sc_q;
        if (bus.wr && sc_hit) begin
            // end flag may only be cleared, never set, by a write
            sc_w[6:0] = bus.wdata[6:0];
            if (!bus.wdata[atc_pkg::BIT_END_FLAG]) begin
                sc_w[atc_pkg::BIT_END_FLAG] = 1'b0;
            end
        end
        if (trig_fire) begin
            sc_w[atc_pkg::BIT_START] = 1'b1;
        end
    end

    // legal channel codes, judged on the code written with the start so that a
    // start and a prohibited code arriving together are refused at once
    always_comb begin
        if (sc_w[atc_pkg::BIT_SCAN]) begin
            code_ok = sc_w[3:2] == 2'h0;
        end else begin
            code_ok = (sc_w[3:2] == 2'h0) || (sc_w[3:1] == 3'h7);
        end
    end

    // trigger/time and mask writes; reserved positions are never stored
    always_comb begin
        tc_d   = tc_q;
        mask_d = mask_q;
        if (bus.wr && tc_hit) begin
            // holding these fields during a conversion is software's duty
            tc_d = {bus.wdata[7:6], bus.wdata[3:2]};
        end
        if (bus.wr && mask_hit) begin
            mask_d = bus.wdata[atc_pkg::EV_W-1:0];
        end
    end

    assign group_end = chan_q == {2'h0, sc_q[1:0]};

    // start sources and single/scan sequencing
    always_comb begin
        sc_d      = sc_w;
        st_d      = st_q;
        chan_d    = chan_q;
        last_d    = last_q;
        conv_load = 1'b0;
        end_set   = 1'b0;
        bad_set   = 1'b0;
        unique case (st_q)
            atc_pkg::ST_IDLE: begin
                if (sc_w[atc_pkg::BIT_START]) begin
                    if (code_ok) begin
                        st_d      = atc_pkg::ST_CONV;
                        conv_load = 1'b1;
                        chan_d    = sc_w[atc_pkg::BIT_SCAN] ? 4'h0 : sc_w[3:0];
                    end else begin
                        // a refused start leaves no trace but the status bit
                        sc_d[atc_pkg::BIT_START] = 1'b0;
                        bad_set                  = 1'b1;
                    end
                end
            end
            atc_pkg::ST_CONV: begin
                if (!sc_w[atc_pkg::BIT_START]) begin
                    st_d = atc_pkg::ST_IDLE;                              // stopped by software
                end else if (conv_done) begin
                    last_d = chan_q;
                    if (!sc_q[atc_pkg::BIT_SCAN]) begin
                        sc_d[atc_pkg::BIT_START]    = 1'b0;
                        sc_d[atc_pkg::BIT_END_FLAG] = 1'b1;
                        end_set                     = 1'b1;
                        st_d                        = atc_pkg::ST_IDLE;
                    end else begin
                        // scan reloads the timer at once; the group wraps to channel 0
                        conv_load = 1'b1;
                        if (group_end) begin
                            chan_d                      = 4'h0;
                            sc_d[atc_pkg::BIT_END_FLAG] = 1'b1;
                            end_set                     = 1'b1;
                        end else begin
                            chan_d = chan_q + 4'h1;
                        end
                    end
                end
            end
        endcase
    end

    // sticky events; a read clears them, but an event in the same cycle wins
    always_comb begin
        ev_d = ev_q;
        if (bus.rd && ev_hit) begin
            ev_d = '0;
        end
        if (end_set) begin
            ev_d[atc_pkg::EV_END] = 1'b1;
        end
        if (trig_fire) begin
            ev_d[atc_pkg::EV_TRIG] = 1'b1;
        end
        if (bad_set) begin
            ev_d[atc_pkg::EV_BAD_CODE] = 1'b1;
        end
    end

    // read mux, data valid the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                atc_pkg::OFS_STATUS_CTRL: rdata_d = sc_q;
                atc_pkg::OFS_TRIG_CLK:    rdata_d = {tc_q[3:2], 2'h0, tc_q[1:0], 2'h0}
                                                    | atc_pkg::TC_FIXED_ONES;
                atc_pkg::OFS_IRQ_STATUS:  rdata_d = {5'h00, ev_q};
                atc_pkg::OFS_IRQ_MASK:    rdata_d = {5'h00, mask_q};
                atc_pkg::OFS_RESULT:      rdata_d = {4'h0, last_q};
                default:                  rdata_d = 8'h00;
            endcase
        end
    end

    // level interrupt built from next status and mask, so it never lags them
    always_comb begin
        irq_d = |(ev_d & mask_d);
    end

    // software registers, with the sequencer's updates folded in
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sc_q   <= atc_pkg::SC_RESET;
            tc_q   <= 4'h0;
            mask_q <= '0;
        end else begin
            sc_q   <= sc_d;
            tc_q   <= tc_d;
            mask_q <= mask_d;
        end
    end

    // sequencer state and channel bookkeeping
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q   <= atc_pkg::ST_IDLE;
            chan_q <= 4'h0;
            last_q <= 4'h0;
        end else begin
            st_q   <= st_d;
            chan_q <= chan_d;
            last_q <= last_d;
        end
    end

    // events and interrupt line in one group so they never disagree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ev_q  <= '0;
            irq_q <= 1'b0;
        end else begin
            ev_q  <= ev_d;
            irq_q <= irq_d;
        end
    end

    // read data register: zero except in the cycle after a read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    atc_timer u_timer (
        .clk   (clk),
        .reset (reset),
        .load  (conv_load),
        .run   (st_q == atc_pkg::ST_CONV && sc_q[atc_pkg::BIT_START]),
        .span  (span),
        .done  (conv_done)
    );

    assign rdata      = rdata_q;
    assign irq        = irq_q;
    assign converting = st_q[1];        // one-hot conversion bit, no gate after the flop
    assign channel    = chan_q;
endmodule : atc_ctrl

/* File: rtl/atc_pkg.sv */
// Purpose: shared constants and types for the converter trigger and timing control
// Assumes: 8-bit registers on a plain port, 50 MHz system clock
// Notes:   offsets are local choices; conversion times are counted in system states
package atc_pkg;

    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFS_STATUS_CTRL = 4'h0;   // status / start / mode / channel
    localparam logic [3:0]  OFS_TRIG_CLK    = 4'h1;   // trigger and time select
    localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h2;   // sticky events, read clears
    localparam logic [3:0]  OFS_IRQ_MASK    = 4'h3;   // event mask
    localparam logic [3:0]  OFS_RESULT      = 4'h4;   // last channel converted

    // status/control layout
    localparam int BIT_END_FLAG  = 7;
    localparam int BIT_IRQ_EN    = 6;
    localparam int BIT_START     = 5;
    localparam int BIT_SCAN      = 4;
    // trigger/clock layout
    localparam int POS_TRIG      = 6;
    localparam int POS_CKS       = 2;
    localparam logic [7:0] TC_FIXED_ONES = 8'h33;   // bits 5,4,1,0 read as one
    localparam logic [7:0] SC_RESET      = 8'h00;

    // interrupt status bits
    localparam int EV_END      = 0;
    localparam int EV_TRIG     = 1;
    localparam int EV_BAD_CODE = 2;
    localparam int EV_W        = 3;

    // trigger source codes
    localparam logic [1:0] TRG_SOFT = 2'h0;
    localparam logic [1:0] TRG_TMR  = 2'h1;
    localparam logic [1:0] TRG_BAD  = 2'h2;
    localparam logic [1:0] TRG_EXT  = 2'h3;

    // maximum conversion time in states for each clock select code
    localparam logic [9:0] CONV_T0 = 10'd530;
    localparam logic [9:0] CONV_T1 = 10'd266;
    localparam logic [9:0] CONV_T2 = 10'd134;
    localparam logic [9:0] CONV_T3 = 10'd68;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } atc_bus_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } atc_state_t;

endpackage : atc_pkg

/* File: rtl/atc_timer.sv */
// Purpose: conversion time counter for one channel
// Assumes: load pulse restarts the count, done is a one-cycle pulse
// Notes:   kept apart so the main file holds only control logic
`timescale 1ns/10ps
module atc_timer (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic       run,
    input  wire logic [9:0] span,
    output logic            done
);
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic       done_q;
    logic       done_d;

    // count down while running; a stopped run drops the count quietly
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = span - 10'd1;
        end else if (!run) begin
            cnt_d = 10'h000;
        end else if (cnt_q == 10'h001) begin
            cnt_d  = 10'h000;
            done_d = 1'b1;
        end else if (cnt_q != 10'h000) begin
            cnt_d = cnt_q - 10'd1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q  <= 10'h000;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule : atc_timer
